// ==== olmpc_defs.svh ====
// Register offsets, field positions, reset values and timing counts for the one-line port configuration block
`ifndef OLMPC_DEFS_SVH
`define OLMPC_DEFS_SVH
`define OLMPC_ADDR_SPEED 8'h03
`define OLMPC_ADDR_FORMAT 8'h04
`define OLMPC_ADDR_ROLE 8'h05
`define OLMPC_ADDR_STATUS 8'h06
`define OLMPC_ADDR_MEASURE 8'h07
`define OLMPC_CODEC_FM_LSB 6
`define OLMPC_AUX_FM_LSB 4
`define OLMPC_ADC_SEL_LSB 2
`define OLMPC_CFG_LSB 0
`define OLMPC_DIF_LSB 5
`define OLMPC_ADC_OL_LSB 3
`define OLMPC_DAC_OL_LSB 1
`define OLMPC_CODEC_MS_BIT 7
`define OLMPC_AUX_MS_BIT 6
`define OLMPC_EXT_CLK_BIT 5
`define OLMPC_SPEED_RST 8'h00
`define OLMPC_FORMAT_RST 8'h00
`define OLMPC_ROLE_RST 8'h00
`define OLMPC_RATIO_TOL 10'h004
`endif

// ==== olmpc_pkg.sv ====
// Types for the one-line port configuration block
`default_nettype none
package olmpc_pkg;
  typedef enum logic [1:0] {OLMPC_OL_NONE, OLMPC_OL_ONE, OLMPC_OL_TWO, OLMPC_OL_BAD} olmpc_ol_t;
  typedef enum logic [1:0] {OLMPC_SPD_SINGLE, OLMPC_SPD_DOUBLE, OLMPC_SPD_QUAD, OLMPC_SPD_BAD} olmpc_spd_t;
  typedef struct packed {
    logic [1:0] codec_ratio; // 0:64 1:128 2:256 Fs
    logic [1:0] aux_ratio;
    logic [2:0] codec_speeds; // Allowed speeds bit per olmpc_spd_t
    logic valid;
  } olmpc_plan_t;
  typedef struct packed {
    logic codec_out_adc;
    logic aux_out_adc;
    logic aux_out_spdif;
    logic fixed_format;
  } olmpc_route_t;
endpackage
`default_nettype wire

// ==== olmpc_clk_meter.sv ====
// Counts bit clock edges per frame clock period of a sampled link clock pair
`timescale 1ns/1ns
`default_nettype none
module olmpc_clk_meter (
  input wire logic ref_clk_i, // System clock
  input wire logic reset_i, // Async reset, active high
  input wire logic bit_clk_i, // Bit clock pin
  input wire logic frame_clk_i, // Frame clock pin
  output logic [9:0] bits_per_frame_o, // Bit clocks in last frame
  output logic frame_done_o // Pulse at frame start
);
  logic [1:0] bit_sync_ff;
  logic [1:0] frame_sync_ff;
  logic bit_prev_ff;
  logic frame_prev_ff;
  logic [9:0] bit_cnt_ff;
  // Second stage only feeds edge detection; first stage is never read elsewhere
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      bit_sync_ff <= 2'h0;
      frame_sync_ff <= 2'h0;
      bit_prev_ff <= 1'h0;
      frame_prev_ff <= 1'h0;
    end else begin
      bit_sync_ff <= {bit_sync_ff[0], bit_clk_i};
      frame_sync_ff <= {frame_sync_ff[0], frame_clk_i};
      bit_prev_ff <= bit_sync_ff[1];
      frame_prev_ff <= frame_sync_ff[1];
    end
  end
  wire logic bit_rise = bit_sync_ff[1] & ~bit_prev_ff;
  wire logic frame_rise = frame_sync_ff[1] & ~frame_prev_ff;
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      bit_cnt_ff <= 10'h000;
      bits_per_frame_o <= 10'h000;
      frame_done_o <= 1'h0;
    end else begin
      frame_done_o <= frame_rise;
      if (frame_rise) begin
        bits_per_frame_o <= bit_cnt_ff + {9'h000, bit_rise};
        bit_cnt_ff <= 10'h000;
      end else if (bit_rise && bit_cnt_ff != 10'h3ff) begin
        bit_cnt_ff <= bit_cnt_ff + 10'h001;
      end
    end
  end
endmodule // olmpc_clk_meter
`default_nettype wire

// ==== olmpc_top.sv ====
// Function
// - Config one carries 8 DAC, 6 ADC, 2 receiver channels; 24-bit at 48 kHz.
// - Config one, select 00: ADC on codec output, receiver on aux output.
// - Format field applies only outside one-line modes; otherwise mode fixes format.
// - No one-line mode: codec and aux bit clocks 64 Fs, any speed.
// - Config one, mode 1 without mode 2: codec 128 Fs, single/double, aux 64 Fs.
// - Config one ADC mode 2: codec 256 Fs, single; DAC none or mode 2.
// - Config two carries no receiver data; 20-bit at 96 kHz.
// - Select 10: ADC data on aux output with aux clocks, no receiver data.
// - Config two, ADC mode 1, DAC none: codec 64 Fs single/double, aux 128 Fs.
// - Config two, both mode 1: codec and aux 128 Fs, single speed.
// - Config two ADC mode 2 only with DAC none: aux 256, codec 64, single.
// - Config three: 8 DAC, 6 ADC, 2 receiver, 20-bit at 48 kHz, no mode 2.
// - Config three, select 00: ADC on codec output and clocks, receiver on aux.
// - Config three, any mode 1: codec 128 Fs single only, aux 64 Fs.
// - Single speed 32-48 kHz, double 64-96 kHz, quad 176.4-192 kHz.
`timescale 1ns/1ns
`default_nettype none
`include "olmpc_defs.svh"
module olmpc_top import olmpc_pkg::*; (
  input wire logic ref_clk_i, // 125 MHz system clock
  input wire logic reset_i, // Async reset, active high
  input wire logic [7:0] reg_addr_i, // Register address
  input wire logic [7:0] reg_wdata_i, // Write data
  input wire logic reg_wr_i, // Write strobe
  input wire logic reg_rd_i, // Read strobe
  output logic [7:0] reg_rdata_o, // Read data, cycle after strobe
  input wire logic codec_port_bit_clock_i, // Codec port bit clock pin
  input wire logic codec_port_frame_clock_i, // Codec port frame clock pin
  input wire logic aux_port_bit_clock_i, // Aux port bit clock pin
  input wire logic aux_port_frame_clock_i, // Aux port frame clock pin
  input wire logic adc_data_i, // Serialised ADC stream
  input wire logic spdif_data_i, // Serialised receiver stream
  output logic codec_port_serial_out_o, // Codec serial output
  output logic aux_port_serial_out_o, // Aux serial output
  output logic config_valid_o, // Programmed combination is legal
  output logic clock_error_o // Measured clock ratio disagrees
);
  logic [7:0] speed_ff;
  logic [7:0] format_ff;
  logic [7:0] role_ff;
  logic [1:0] adc_sync_ff;
  logic [1:0] spdif_sync_ff;
  logic [9:0] codec_bits;
  logic [9:0] aux_bits;
  logic codec_frame;
  logic aux_frame;
  logic codec_bad_ff;
  logic aux_bad_ff;
  olmpc_plan_t plan;
  olmpc_route_t route;
  ////////////////////////////////////////////////////////////////////////////
  wire logic [1:0] codec_fm = speed_ff[`OLMPC_CODEC_FM_LSB +: 2];
  wire logic [1:0] aux_fm = speed_ff[`OLMPC_AUX_FM_LSB +: 2];
  wire logic [1:0] adc_sel = speed_ff[`OLMPC_ADC_SEL_LSB +: 2];
  wire logic [1:0] cfg = speed_ff[`OLMPC_CFG_LSB +: 2]; // 0..2 mean configs one..three
  wire logic [2:0] dif = format_ff[`OLMPC_DIF_LSB +: 3];
  wire olmpc_ol_t adc_ol = olmpc_ol_t'(format_ff[`OLMPC_ADC_OL_LSB +: 2]);
  wire olmpc_ol_t dac_ol = olmpc_ol_t'(format_ff[`OLMPC_DAC_OL_LSB +: 2]);
  wire logic codec_ms = role_ff[`OLMPC_CODEC_MS_BIT];
  wire logic aux_ms = role_ff[`OLMPC_AUX_MS_BIT];
  wire logic ext_clk = role_ff[`OLMPC_EXT_CLK_BIT];
  ////////////////////////////////////////////////////////////////////////////
  // Register write port
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      speed_ff <= `OLMPC_SPEED_RST;
      format_ff <= `OLMPC_FORMAT_RST;
      role_ff <= `OLMPC_ROLE_RST;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `OLMPC_ADDR_SPEED: speed_ff <= reg_wdata_i;
        `OLMPC_ADDR_FORMAT: format_ff <= reg_wdata_i;
        `OLMPC_ADDR_ROLE: role_ff <= {reg_wdata_i[7:5], 5'h00};
        default: ;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Legal bit clock ratio and speed table per configuration and mode pair
  always_comb begin
    plan = '{codec_ratio: 2'h0, aux_ratio: 2'h0, codec_speeds: 3'h7, valid: 1'h1};
    if (adc_ol == OLMPC_OL_BAD || dac_ol == OLMPC_OL_BAD || cfg == 2'h3) begin
      plan.valid = 1'h0;
    end else if (adc_ol == OLMPC_OL_NONE && dac_ol == OLMPC_OL_NONE) begin
      plan.valid = 1'h1;
    end else begin
      case (cfg)
        2'h0: begin
          if (adc_ol == OLMPC_OL_TWO && dac_ol != OLMPC_OL_ONE) begin
            plan.codec_ratio = 2'h2;
            plan.codec_speeds = 3'h1;
          end else if (dac_ol == OLMPC_OL_TWO) begin
            plan.valid = 1'h0;
          end else if (adc_ol == OLMPC_OL_TWO) begin
            plan.valid = 1'h0;
          end else begin
            plan.codec_ratio = 2'h1;
            plan.codec_speeds = 3'h3;
          end
        end
        2'h1: begin
          if (dac_ol == OLMPC_OL_TWO) begin
            plan.valid = 1'h0;
          end else if (adc_ol == OLMPC_OL_TWO) begin
            plan.valid = (dac_ol == OLMPC_OL_NONE);
            plan.aux_ratio = 2'h2;
            plan.codec_speeds = 3'h1;
          end else if (adc_ol == OLMPC_OL_ONE && dac_ol == OLMPC_OL_ONE) begin
            plan.codec_ratio = 2'h1;
            plan.aux_ratio = 2'h1;
            plan.codec_speeds = 3'h1;
          end else if (adc_ol == OLMPC_OL_ONE) begin
            plan.aux_ratio = 2'h1;
            plan.codec_speeds = 3'h3;
          end else begin
            plan.codec_ratio = 2'h1;
            plan.codec_speeds = 3'h1;
          end
        end
        2'h2: begin
          if (adc_ol == OLMPC_OL_TWO || dac_ol == OLMPC_OL_TWO) begin
            plan.valid = 1'h0;
          end else begin
            plan.codec_ratio = 2'h1;
            plan.codec_speeds = 3'h1;
          end
        end
        default: plan.valid = 1'h0;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Routing of ADC and receiver data
  always_comb begin
    route = '{codec_out_adc: 1'h0, aux_out_adc: 1'h0, aux_out_spdif: 1'h0, fixed_format: 1'h0};
    route.fixed_format = (adc_ol != OLMPC_OL_NONE) || (dac_ol != OLMPC_OL_NONE);
    if (adc_sel == 2'h2) begin
      route.aux_out_adc = 1'h1;
    end else if (adc_sel == 2'h0 && cfg != 2'h1) begin
      route.codec_out_adc = 1'h1;
      route.aux_out_spdif = 1'h1;
    end
  end
  // Host-owned settings that the whole table depends on
  wire logic host_ok = (codec_fm == aux_fm) && (codec_fm != 2'h3) && codec_ms
    && (cfg != 2'h0 || (aux_ms && !ext_clk))
    && (cfg == 2'h0 || ext_clk)
    && (cfg != 2'h1 || aux_ms)
    && (cfg == 2'h1 ? adc_sel == 2'h2 : adc_sel == 2'h0);
  // Speed code 3 maps to a zero entry so the index never leaves the table
  wire logic [3:0] speed_map = {1'h0, plan.codec_speeds};
  wire logic speed_ok = speed_map[codec_fm];
  wire logic cfg_ok = plan.valid && host_ok && speed_ok;
  ////////////////////////////////////////////////////////////////////////////
  // Serial data synchronisers and output steering
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      adc_sync_ff <= 2'h0;
      spdif_sync_ff <= 2'h0;
    end else begin
      adc_sync_ff <= {adc_sync_ff[0], adc_data_i};
      spdif_sync_ff <= {spdif_sync_ff[0], spdif_data_i};
    end
  end
  // Outputs are held low when invalid so the host never sees undefined streams
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      codec_port_serial_out_o <= 1'h0;
      aux_port_serial_out_o <= 1'h0;
    end else begin
      codec_port_serial_out_o <= cfg_ok & route.codec_out_adc & adc_sync_ff[1];
      aux_port_serial_out_o <= cfg_ok & ((route.aux_out_adc & adc_sync_ff[1])
        | (route.aux_out_spdif & spdif_sync_ff[1]));
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Bit clock ratio measurement
  olmpc_clk_meter u_codec_meter (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .bit_clk_i(codec_port_bit_clock_i),
    .frame_clk_i(codec_port_frame_clock_i),
    .bits_per_frame_o(codec_bits),
    .frame_done_o(codec_frame)
  );
  olmpc_clk_meter u_aux_meter (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .bit_clk_i(aux_port_bit_clock_i),
    .frame_clk_i(aux_port_frame_clock_i),
    .bits_per_frame_o(aux_bits),
    .frame_done_o(aux_frame)
  );
  function automatic logic ratio_off(input logic [9:0] bits, input logic [1:0] ratio);
    logic [9:0] want;
    want = 10'h040 << ratio;
    ratio_off = (bits + `OLMPC_RATIO_TOL < want) || (bits > want + `OLMPC_RATIO_TOL);
  endfunction
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      codec_bad_ff <= 1'h0;
      aux_bad_ff <= 1'h0;
    end else begin
      if (codec_frame) codec_bad_ff <= ratio_off(codec_bits, plan.codec_ratio);
      if (aux_frame) aux_bad_ff <= ratio_off(aux_bits, plan.aux_ratio);
    end
  end
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      config_valid_o <= 1'h0;
      clock_error_o <= 1'h0;
    end else begin
      config_valid_o <= cfg_ok;
      clock_error_o <= codec_bad_ff | aux_bad_ff;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Register read port
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `OLMPC_ADDR_SPEED: reg_rdata_o <= speed_ff;
        `OLMPC_ADDR_FORMAT: reg_rdata_o <= format_ff;
        `OLMPC_ADDR_ROLE: reg_rdata_o <= role_ff;
        `OLMPC_ADDR_STATUS: reg_rdata_o <= {(route.fixed_format ? 3'h0 : dif), route.fixed_format,
          codec_bad_ff, aux_bad_ff, speed_ok, cfg_ok};
        `OLMPC_ADDR_MEASURE: reg_rdata_o <= codec_bits[9:2];
        default: reg_rdata_o <= 8'h00;
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  cfg_two_aux_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (cfg == 2'h1 && cfg_ok) |=> !aux_port_serial_out_o || $past(adc_sync_ff[1]))
    else $error("config two put non-ADC data on aux output");
  codec_route_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    codec_port_serial_out_o |-> $past(cfg_ok && adc_sel == 2'h0))
    else $error("codec output driven without ADC routing");
  sel10_codec_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (adc_sel == 2'h2) ##1 (adc_sel == 2'h2) |-> !codec_port_serial_out_o)
    else $error("codec output active with aux routing");
  dac_two_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (cfg != 2'h0 && dac_ol == OLMPC_OL_TWO) |=> !config_valid_o)
    else $error("DAC mode two accepted outside config one");
  cfg3_mode2_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (cfg == 2'h2 && adc_ol == OLMPC_OL_TWO) |=> !config_valid_o)
    else $error("mode two accepted in config three");
  speed_eq_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    config_valid_o |-> $past(codec_fm == aux_fm))
    else $error("unequal speed fields accepted");
  mode2_single_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (adc_ol == OLMPC_OL_TWO && codec_fm != 2'h0) |=> !config_valid_o)
    else $error("mode two accepted above single speed");
  cfg1_mode1_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (cfg == 2'h0 && adc_ol == OLMPC_OL_ONE && (dac_ol == OLMPC_OL_NONE || dac_ol == OLMPC_OL_ONE))
    |-> plan.codec_ratio == 2'h1)
    else $error("config one mode one ratio wrong");
  cfg2_both1_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (cfg == 2'h1 && adc_ol == OLMPC_OL_ONE && dac_ol == OLMPC_OL_ONE) |-> plan.aux_ratio == 2'h1 && plan.codec_speeds == 3'h1)
    else $error("config two dual mode one wrong");
  valid_cv: cover property (@(posedge ref_clk_i) disable iff (reset_i) $rose(config_valid_o));
  aux_adc_cv: cover property (@(posedge ref_clk_i) disable iff (reset_i) route.aux_out_adc && cfg_ok);
  clkerr_cv: cover property (@(posedge ref_clk_i) disable iff (reset_i) $rose(clock_error_o));
endmodule // olmpc_top
`default_nettype wire

// ==== olmpc_partner.sv ====
// Host-side model that makes the bit and frame clocks of both serial ports
`timescale 1ns/1ns
`default_nettype none
module olmpc_partner (
  input var int codec_ratio_i, // Codec bit clocks per frame
  input var int aux_ratio_i, // Aux bit clocks per frame
  input wire logic run_i, // Frames are sent while high
  output logic codec_port_bit_clock_o, // Codec port bit clock
  output logic codec_port_frame_clock_o, // Codec port frame clock
  output logic aux_port_bit_clock_o, // Aux port bit clock
  output logic aux_port_frame_clock_o // Aux port frame clock
);
  initial begin
    codec_port_frame_clock_o = 1'b0;
    aux_port_frame_clock_o = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Codec port: 125 ns bit clock; ratio latched so a change never splits a frame
  always begin : codec_side
    int n;
    codec_port_bit_clock_o = 1'b0;
    wait (run_i);
    n = codec_ratio_i;
    for (int b = 0; b < n; b++) begin
      codec_port_frame_clock_o = (b >= n / 2);
      #62 codec_port_bit_clock_o = 1'b1;
      #63 codec_port_bit_clock_o = 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Aux port: bit rate scaled so both frames share one rate, no conversion
  always begin : aux_side
    int n;
    int h;
    aux_port_bit_clock_o = 1'b0;
    wait (run_i);
    n = aux_ratio_i;
    h = codec_ratio_i * 125 / (2 * n);
    for (int b = 0; b < n; b++) begin
      aux_port_frame_clock_o = (b >= n / 2);
      #h aux_port_bit_clock_o = 1'b1;
      #h aux_port_bit_clock_o = 1'b0;
    end
  end
endmodule // olmpc_partner
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the one-line port configuration block
`timescale 1ns/1ns
`default_nettype none
`include "olmpc_defs.svh"
module testbench;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0, rd = 1'b0, adc = 1'b0, spd = 1'b0, run = 1'b0;
  wire logic cb, cf, ab, af, codec_out, aux_out, valid, cerr;
  wire logic [7:0] rdata;
  int cr = 64, ar = 64, failures = 0, samples_checked = 0, cycles = 0;
  logic [31:0] seed = 32'h0000_0006;
  logic [31:0] x;
  logic [1:0] c;
  logic [7:0] s, rv;
  logic [1:0] q[$];
  // Legal roles and fields mixed with broken ones
  localparam logic [23:0] CORNERS [22] = '{24'h0000c0, 24'h0014c0, 24'h5010c0, 24'h0004c0, 24'h0012c0,
    24'h5008c0, 24'ha008c0, 24'h4000c0, 24'h0000e0, 24'h5908e0, 24'h590ae0, 24'h090ae0, 24'h0910e0,
    24'h0912e0, 24'h0904e0, 24'h0908c0, 24'h0202a0, 24'h5202a0, 24'h0210a0, 24'ha200a0, 24'h0a00a0, 24'h0300e0};

  always #4 ref_clk = ~ref_clk;

  olmpc_top i_olmpc_top (.ref_clk_i(ref_clk), .reset_i(reset), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .codec_port_bit_clock_i(cb),
    .codec_port_frame_clock_i(cf), .aux_port_bit_clock_i(ab), .aux_port_frame_clock_i(af),
    .adc_data_i(adc), .spdif_data_i(spd), .codec_port_serial_out_o(codec_out),
    .aux_port_serial_out_o(aux_out), .config_valid_o(valid), .clock_error_o(cerr));
  olmpc_partner i_olmpc_partner (.codec_ratio_i(cr), .aux_ratio_i(ar), .run_i(run),
    .codec_port_bit_clock_o(cb), .codec_port_frame_clock_o(cf), .aux_port_bit_clock_o(ab),
    .aux_port_frame_clock_o(af));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic exp_valid(input logic [7:0] sp, input logic [7:0] f, input logic [7:0] r);
    logic [1:0] fm, a, d;
    logic ok;
    fm = sp[7:6];
    a = f[4:3];
    d = f[2:1];
    ok = fm == sp[5:4] && fm != 2'h3 && a != 2'h3 && d != 2'h3 && r[7];
    case (sp[1:0])
      2'h0: ok &= sp[3:2] == 2'h0 && r[6] && !r[5] && !(d == 2'h2 && a != 2'h2) && !(a == 2'h2 && d == 2'h1)
        && ((a == 2'h2 || d == 2'h2) ? fm == 2'h0 : ((a | d) == 2'h0 || fm != 2'h2));
      2'h1: ok &= sp[3:2] == 2'h2 && r[6] && r[5] && d != 2'h2 && !(a == 2'h2 && d != 2'h0)
        && ((a == 2'h1 && d == 2'h0) ? fm != 2'h2 : ((a | d) == 2'h0 || fm == 2'h0));
      2'h2: ok &= sp[3:2] == 2'h0 && r[5] && a != 2'h2 && d != 2'h2 && ((a | d) == 2'h0 || fm == 2'h0);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  function automatic int exp_ratio(input logic [7:0] sp, input logic [7:0] f, input bit aux);
    if (aux) begin
      return (sp[1:0] == 2'h1 && f[4:3] == 2'h1) ? 128 : (sp[1:0] == 2'h1 && f[4:3] == 2'h2) ? 256 : 64;
    end
    if (sp[1:0] == 2'h1) begin
      return (f[2:1] == 2'h1) ? 128 : 64;
    end
    return (sp[1:0] == 2'h0 && f[4:3] == 2'h2) ? 256 : (f[4:1] != 4'h0) ? 128 : 64;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    @(negedge ref_clk);
    d = rdata;
  endtask

  // Output must equal the input three edges back, or stay low when not routed
  task automatic stream(input logic [7:0] sp, input logic v);
    logic [31:0] y;
    q = {};
    for (int i = 0; i < 12; i++) begin
      @(posedge ref_clk);
      y = xs();
      adc <= y[0];
      spd <= y[1];
      q.push_back(y[1:0]);
      @(negedge ref_clk);
      if (i >= 3) begin
        check({7'h0, codec_out}, {7'h0, v && sp[3:2] == 2'h0 && q[i-3][0]});
        check({7'h0, aux_out}, {7'h0, v && (sp[3:2] == 2'h2 ? q[i-3][0] : q[i-3][1])});
      end
    end
  endtask

  // Wait on frame edges, not cycles: the partner finishes its last frame after run drops,
  // so the first new frame is mixed and only the later ones count
  task automatic frames();
    run = 1'b1;
    repeat (3) @(posedge cf);
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  task automatic apply(input logic [7:0] sp, input logic [7:0] f, input logic [7:0] r, input bit clk_test);
    logic v;
    logic [7:0] st;
    v = exp_valid(sp, f, r);
    wr_reg(`OLMPC_ADDR_SPEED, sp);
    wr_reg(`OLMPC_ADDR_FORMAT, f);
    wr_reg(`OLMPC_ADDR_ROLE, r);
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    check({7'h0, valid}, {7'h0, v});
    rd_reg(`OLMPC_ADDR_STATUS, st);
    check(st & 8'hf1, {((f[4:1] != 4'h0) ? 3'h0 : f[7:5]), f[4:1] != 4'h0, 3'h0, v});
    stream(sp, v);
    if (clk_test && v) begin
      cr = exp_ratio(sp, f, 1'b0);
      ar = exp_ratio(sp, f, 1'b1);
      frames();
      check({7'h0, cerr}, 8'h00);
      rd_reg(`OLMPC_ADDR_MEASURE, st);
      check(st, 8'(cr / 4));
      run = 1'b0;
    end
  endtask

  task automatic results();
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Longest corner needs about 12000 cycles; the whole run stays near 50000
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 90000) begin
      failures++;
      results();
    end
  end

  initial begin
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    @(negedge ref_clk);
    check({7'h0, valid}, 8'h00);
    rd_reg(`OLMPC_ADDR_SPEED, rv);
    check(rv, 8'h00);
    rd_reg(`OLMPC_ADDR_FORMAT, rv);
    check(rv, 8'h00);
    rd_reg(`OLMPC_ADDR_ROLE, rv);
    check(rv, 8'h00);
    wr_reg(8'h20, 8'hff);
    rd_reg(8'h20, rv);
    check(rv, 8'h00);
    wr_reg(`OLMPC_ADDR_ROLE, 8'hff);
    rd_reg(`OLMPC_ADDR_ROLE, rv);
    check(rv, 8'he0);
    foreach (CORNERS[i]) begin
      apply(CORNERS[i][23:16], CORNERS[i][15:8], CORNERS[i][7:0], 1'b1);
      if (i == 0) begin
        // Wrong bit clock ratio on the codec port must be flagged
        cr = 128;
        frames();
        check({7'h0, cerr}, 8'h01);
        run = 1'b0;
      end
    end
    for (int k = 0; k < 30; k++) begin
      x = xs();
      c = (x[1:0] == 2'h3) ? 2'h2 : x[1:0];
      s = {x[3:2], x[4] ? x[6:5] : x[3:2], (c == 2'h1) ? 2'h2 : 2'h0, c};
      apply(s, x[15:8], {1'b1, x[16] | (c != 2'h2), c != 2'h0, 5'h00}, 1'b0);
    end
    results();
  end
endmodule // testbench
`default_nettype wire
